// [rtl/rsm_regs.svh]
// Function
// - Pin pulse and watchdog pull pin during delay; low supply pulls it in the UV phase instead, then skips the delay
// - Fetch start address from FFFE-FFFF
// - Delay, 4096-cycle wait, then fetch
// - Vector fetch lasts exactly two cycles
// - Recognised pulse: drive pin low minimum
// - Watchdog underflow resets, drives pin low
// - Pin held low during low supply
// - Undervoltage uses rising/falling hysteresis
// - Option field picks one of three levels
// - Undervoltage flag set hardware, cleared writing zero
// - Open-drain pin, only pulled low
// - Option selects one of seven clocks
// - Erased option selects external clock
// - Resonator keeps running during reset
// - Watchdog flag cleared by zero or undervoltage
// - Undervoltage flag survives later resets
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH

// Register byte offsets
`define RSM_CAUSE_OFS 8'h00
`define RSM_IRQ_STAT_OFS 8'h04
`define RSM_IRQ_MASK_OFS 8'h08
`define RSM_STATUS_OFS 8'h0c

// Cause register field positions
`define RSM_CAUSE_WDG_BIT 0
`define RSM_CAUSE_UV_BIT 4

// Interrupt event bit positions
`define RSM_EV_DONE_BIT 0
`define RSM_EV_UV_BIT 1
`define RSM_EV_EXT_BIT 2
`define RSM_EV_WDG_BIT 3

// Reset values
`define RSM_CAUSE_UV_RST 1'b1
`define RSM_CAUSE_WDG_RST 1'b0
`define RSM_IRQ_MASK_RST 4'h0

// Reset vector
`define RSM_VECTOR_HI 16'hfffe
`define RSM_VECTOR_LO 16'hffff

// Timing
`define RSM_CLK_NS 100
`define RSM_MIN_DRIVE_NS 20000
`define RSM_MIN_PULSE_NS 1000
`define RSM_STAB_CYCLES 4096
`define RSM_FETCH_CYCLES 2
`define RSM_DRIVE_CYCLES ((`RSM_MIN_DRIVE_NS + `RSM_CLK_NS - 1) / `RSM_CLK_NS)
`define RSM_PULSE_CYCLES (`RSM_MIN_PULSE_NS / `RSM_CLK_NS)

// Clock source codes and erased option
`define RSM_CLK_EXT 3'h7
`define RSM_CLK_XTAL_MAX 3'h3
`define RSM_CLK_EXT_RC 3'h4
`define RSM_CLK_INT_RC 3'h5
`define RSM_LVD_RESERVED 2'h3
`define RSM_LVD_DEFAULT 2'h2

`endif

// [rtl/rsm_pkg.sv]
package rsm_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    RSM_S_UV,
    RSM_S_DELAY,
    RSM_S_STAB,
    RSM_S_FETCH,
    RSM_S_RUN
  } rsm_state_type;

  // APB request from master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rsm_apb_req_type;

  // Nonvolatile option setting
  typedef struct packed {
    logic [1:0] lvd_level;
    logic [2:0] clk_src;
  } rsm_option_type;

endpackage

// [rtl/rsm_reset_sequence_manager.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rsm_regs.svh"

module rsm_reset_sequence_manager (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire rsm_pkg::rsm_apb_req_type apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Open-drain reset pin
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  // Supply comparators and watchdog
  input wire logic above_rising_i,
  input wire logic below_falling_i,
  input wire logic wdg_underflow_i,
  // Option setting
  input wire rsm_pkg::rsm_option_type option_i,
  // Core side
  output logic core_reset_o,
  output logic vector_fetch_o,
  output logic [15:0] fetch_addr_o,
  output logic [2:0] clk_sel_o,
  output logic [1:0] lvd_level_o,
  output logic osc_run_o,
  output logic irq_o
);
  import rsm_pkg::*;

  localparam logic [12:0] DRIVE_CNT = 13'(`RSM_DRIVE_CYCLES);
  localparam logic [12:0] STAB_CNT = 13'(`RSM_STAB_CYCLES);
  localparam logic [12:0] FETCH_CNT = 13'(`RSM_FETCH_CYCLES);
  localparam logic [12:0] PULSE_CNT = 13'(`RSM_PULSE_CYCLES);
  localparam logic [2:0] SYNC_IDLE = 3'h5; // Pin high, supply below both thresholds

  rsm_state_type state;
  rsm_state_type next_state;
  logic [12:0] cnt;
  logic [12:0] filt_cnt;
  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic pin_s;
  logic rise_s;
  logic fall_s;
  logic uv_low;
  logic ext_req;
  logic wdg_req;
  logic uv_flag;
  logic wdg_flag;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] ev;
  logic cnt_done;
  logic busy;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] next_rdata;
  logic next_err;
  rsm_option_type opt;

  // Asynchronous inputs gathered for synchronising
  assign sync_in = {below_falling_i, above_rising_i, rst_pin_i};

  // Two-stage synchroniser per asynchronous input
  for (genvar g = 0; g < 3; g++) begin : g_sync
    logic meta;
    logic held;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta <= SYNC_IDLE[g];
        held <= SYNC_IDLE[g];
      end else begin
        meta <= sync_in[g];
        held <= meta;
      end
    end
    assign sync_out[g] = held;
  end

  // Synchronised pin and comparator levels
  assign pin_s = sync_out[0];
  assign rise_s = sync_out[1];
  assign fall_s = sync_out[2];

  // Supply low state with hysteresis
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uv_low <= 1'b1;
    end else if (fall_s) begin
      uv_low <= 1'b1;
    end else if (rise_s) begin
      uv_low <= 1'b0;
    end
  end

  // Pin low-pulse filter, idle while the block drives the pin
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_cnt <= 13'h0;
    end else if (pin_s || busy) begin
      filt_cnt <= 13'h0;
    end else if (filt_cnt != PULSE_CNT) begin
      filt_cnt <= filt_cnt + 13'h1;
    end
  end

  // Pulses shorter than the minimum width are dropped
  assign ext_req = !busy && !pin_s && (filt_cnt == PULSE_CNT - 13'h1);

  // Watchdog underflow ignored while the pin is already driven
  assign wdg_req = wdg_underflow_i && (state != RSM_S_UV) && (state != RSM_S_DELAY);

  // Pin-driving phases and phase counter expiry
  assign busy = (state == RSM_S_UV) || (state == RSM_S_DELAY);
  assign cnt_done = (cnt == 13'h0);

  // Next phase of the sequence
  always_comb begin
    next_state = state;
    if (uv_low) begin
      next_state = RSM_S_UV;
    end else if (ext_req || wdg_req) begin
      next_state = RSM_S_DELAY;
    end else begin
      case (state)
        RSM_S_UV: begin
          next_state = RSM_S_STAB;
        end
        RSM_S_DELAY: begin
          if (cnt_done) begin
            next_state = RSM_S_STAB;
          end
        end
        RSM_S_STAB: begin
          if (cnt_done) begin
            next_state = RSM_S_FETCH;
          end
        end
        RSM_S_FETCH: begin
          if (cnt_done) begin
            next_state = RSM_S_RUN;
          end
        end
        RSM_S_RUN: begin
          next_state = RSM_S_RUN;
        end
        default: begin
          next_state = RSM_S_UV;
        end
      endcase
    end
  end

  // Phase register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= RSM_S_UV;
    end else begin
      state <= next_state;
    end
  end

  // Phase length counter, loaded on each phase entry
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 13'h0;
    end else if (next_state != state || ext_req || wdg_req) begin
      case (next_state)
        RSM_S_DELAY: cnt <= DRIVE_CNT - 13'h1;
        RSM_S_STAB: cnt <= STAB_CNT - 13'h1;
        RSM_S_FETCH: cnt <= FETCH_CNT - 13'h1;
        default: cnt <= 13'h0;
      endcase
    end else if (!cnt_done) begin
      cnt <= cnt - 13'h1;
    end
  end

  // Open-drain pin: only ever pulled low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_n_o <= 1'b0;
    end else begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_n_o <= !((next_state == RSM_S_UV) || (next_state == RSM_S_DELAY));
    end
  end

  // Core reset and vector fetch
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_reset_o <= 1'b1;
      vector_fetch_o <= 1'b0;
      fetch_addr_o <= `RSM_VECTOR_HI;
    end else begin
      core_reset_o <= (next_state != RSM_S_RUN);
      vector_fetch_o <= (next_state == RSM_S_FETCH);
      if (next_state == RSM_S_FETCH && state != RSM_S_FETCH) begin
        fetch_addr_o <= `RSM_VECTOR_HI;
      end else if (state == RSM_S_FETCH) begin
        fetch_addr_o <= `RSM_VECTOR_LO;
      end
    end
  end

  // Option setting captured during reset phases
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt <= '{lvd_level: `RSM_LVD_RESERVED, clk_src: `RSM_CLK_EXT};
    end else if (next_state != RSM_S_RUN) begin
      opt <= option_i;
    end
  end

  // Clock source, detector level and oscillator run
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sel_o <= `RSM_CLK_EXT;
      lvd_level_o <= `RSM_LVD_DEFAULT;
      osc_run_o <= 1'b0;
    end else begin
      if (opt.clk_src <= `RSM_CLK_INT_RC) begin
        clk_sel_o <= opt.clk_src;
      end else begin
        clk_sel_o <= `RSM_CLK_EXT;
      end
      if (opt.lvd_level == `RSM_LVD_RESERVED) begin
        lvd_level_o <= `RSM_LVD_DEFAULT;
      end else begin
        lvd_level_o <= opt.lvd_level;
      end
      // Resonators stay on through reset, others only in run
      osc_run_o <= (opt.clk_src <= `RSM_CLK_XTAL_MAX) || (next_state == RSM_S_RUN);
    end
  end

  // APB strobes, write at the completing edge, read one cycle before it
  assign apb_wr = apb_i.psel && apb_i.penable && pready_o && apb_i.pwrite;
  assign apb_rd = apb_i.psel && apb_i.penable && !pready_o && !apb_i.pwrite;

  // Events for sticky status
  assign ev[`RSM_EV_DONE_BIT] = (state == RSM_S_FETCH) && (next_state == RSM_S_RUN);
  assign ev[`RSM_EV_UV_BIT] = uv_low && (state != RSM_S_UV);
  assign ev[`RSM_EV_EXT_BIT] = ext_req;
  assign ev[`RSM_EV_WDG_BIT] = wdg_req;

  // Reset cause flags, hardware set wins over software clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uv_flag <= `RSM_CAUSE_UV_RST;
      wdg_flag <= `RSM_CAUSE_WDG_RST;
    end else begin
      if (uv_low) begin
        uv_flag <= 1'b1;
      end else if (apb_wr && apb_i.paddr == `RSM_CAUSE_OFS
                   && !apb_i.pwdata[`RSM_CAUSE_UV_BIT]) begin
        uv_flag <= 1'b0;
      end
      if (uv_low) begin
        wdg_flag <= 1'b0;
      end else if (wdg_req) begin
        wdg_flag <= 1'b1;
      end else if (apb_wr && apb_i.paddr == `RSM_CAUSE_OFS
                   && !apb_i.pwdata[`RSM_CAUSE_WDG_BIT]) begin
        wdg_flag <= 1'b0;
      end
    end
  end

  // Sticky status per event, set wins over write-one clear
  for (genvar b = 0; b < 4; b++) begin : g_stat
    logic flag;
    logic clr;
    assign clr = apb_wr && (apb_i.paddr == `RSM_IRQ_STAT_OFS) && apb_i.pwdata[b];
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        flag <= 1'b0;
      end else if (ev[b]) begin
        flag <= 1'b1;
      end else if (clr) begin
        flag <= 1'b0;
      end
    end
    assign irq_stat[b] = flag;
  end

  // Interrupt mask
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask <= `RSM_IRQ_MASK_RST;
    end else if (apb_wr && apb_i.paddr == `RSM_IRQ_MASK_OFS) begin
      irq_mask <= apb_i.pwdata[3:0];
    end
  end

  // Interrupt line
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Read mux and unmapped detection
  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (apb_i.paddr)
      `RSM_CAUSE_OFS: begin
        next_rdata[`RSM_CAUSE_UV_BIT] = uv_flag;
        next_rdata[`RSM_CAUSE_WDG_BIT] = wdg_flag;
      end
      `RSM_IRQ_STAT_OFS: next_rdata[3:0] = irq_stat;
      `RSM_IRQ_MASK_OFS: next_rdata[3:0] = irq_mask;
      `RSM_STATUS_OFS: begin
        next_rdata[2:0] = state;
        next_rdata[3] = uv_low;
        next_rdata[4] = pin_s;
        next_rdata[10:8] = clk_sel_o;
        next_rdata[13:12] = lvd_level_o;
      end
      default: next_err = 1'b1;
    endcase
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= apb_i.psel && apb_i.penable && !pready_o;
      pslverr_o <= apb_i.psel && apb_i.penable && !pready_o && next_err;
      if (apb_rd) begin
        prdata_o <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

// [test/rsm_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rsm_regs.svh"

module rsm_asserts (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n_o,
  input wire logic below_falling_i,
  input wire logic wdg_underflow_i,
  input wire rsm_pkg::rsm_option_type option_i,
  input wire logic core_reset_o,
  input wire logic vector_fetch_o,
  input wire logic [15:0] fetch_addr_o,
  input wire logic osc_run_o
);
  import rsm_pkg::*;
  localparam int DRV = `RSM_DRIVE_CYCLES;
  localparam int STAB = `RSM_STAB_CYCLES;
  logic [8:0] drv_cnt;
  logic [12:0] st_cnt;
  logic wdg_seen;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Pin-low and pin-released cycle counters
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_cnt <= 9'h000;
      st_cnt <= 13'h0000;
      wdg_seen <= 1'b0;
    end else begin
      drv_cnt <= rst_pin_oe_n_o ? 9'h000 : drv_cnt + {8'h00, ~&drv_cnt};
      st_cnt <= rst_pin_oe_n_o ? st_cnt + 13'h0001 : 13'h0000;
      wdg_seen <= (wdg_underflow_i && !core_reset_o) || (wdg_seen && !vector_fetch_o);
    end
  end
  // Two fetch cycles, high word address then low
  sequence fetch_pair_s;
    vector_fetch_o && fetch_addr_o == 16'hfffe ##1 vector_fetch_o && fetch_addr_o == 16'hffff;
  endsequence
  fetch_pair_a: assert property (
    $rose(vector_fetch_o) |-> fetch_pair_s ##1 !vector_fetch_o && !core_reset_o)
    else $error("vector fetch wrong");
  wdg_start_a: assert property (
    wdg_underflow_i && !core_reset_o |=> !rst_pin_oe_n_o && core_reset_o)
    else $error("watchdog did not reset");
  drive_min_a: assert property (
    $rose(rst_pin_oe_n_o) && wdg_seen |-> drv_cnt >= DRV) else $error("drive too short");
  stab_wait_a: assert property (
    $rose(vector_fetch_o) |-> st_cnt == STAB) else $error("stabilisation wait wrong");
  uv_hold_a: assert property (
    below_falling_i [*4] |=> !rst_pin_oe_n_o && core_reset_o) else $error("low supply not held");
  drive_low_a: assert property (
    rst_pin_o == 1'b0) else $error("pin driven high");
  delay_order_a: assert property (
    !rst_pin_oe_n_o |-> core_reset_o && !vector_fetch_o) else $error("pin low outside delay");
  osc_keep_a: assert property (
    (core_reset_o && option_i.clk_src <= 3'h3) [*3] |-> osc_run_o) else $error("resonator stopped");
endmodule

bind rsm_reset_sequence_manager rsm_asserts u_rsm_asserts (.*);
`default_nettype wire

// [test/rsm_ext_circuit.sv]
`timescale 1ns/1ps
`default_nettype none

module rsm_ext_circuit (
  // Clock and pulse request
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  // Shared reset line
  input wire logic oe_n_i,
  output logic pin_o
);
  logic [7:0] cnt = 8'h00;
  // Weak pull-up unless either side pulls low
  assign pin_o = !(cnt != 8'h00 || !oe_n_i);
  // Hold the line low for the requested span
  always_ff @(posedge clk_i) begin
    cnt <= go_i ? len_i : cnt - {7'h00, cnt != 8'h00};
  end
endmodule
`default_nettype wire

// [test/tb_reset_sequence_manager.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_reset_sequence_manager;
  import rsm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rsm_apb_req_type apb_i = '0;
  rsm_option_type option_i = '{2'h3, 3'h7};
  logic above_rising_i = 1'b0;
  logic below_falling_i = 1'b1;
  logic wdg_underflow_i = 1'b0;
  logic go = 1'b0;
  logic [7:0] plen = 8'h00;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic [15:0] fetch_addr_o;
  logic [2:0] clk_sel_o;
  logic [1:0] lvd_level_o;
  logic pready_o, pslverr_o, pin, rst_pin_o, oe_n, core_reset_o, vector_fetch_o, osc_run_o, irq_o;
  logic err;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  // Clock
  always #50 ref_clk_i = ~ref_clk_i;
  rsm_reset_sequence_manager u_rsm_reset_sequence_manager (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .apb_i(apb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rst_pin_i(pin), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(oe_n),
    .above_rising_i(above_rising_i), .below_falling_i(below_falling_i),
    .wdg_underflow_i(wdg_underflow_i), .option_i(option_i), .core_reset_o(core_reset_o),
    .vector_fetch_o(vector_fetch_o), .fetch_addr_o(fetch_addr_o), .clk_sel_o(clk_sel_o),
    .lvd_level_o(lvd_level_o), .osc_run_o(osc_run_o), .irq_o(irq_o));
  rsm_ext_circuit u_rsm_ext_circuit (.clk_i(ref_clk_i), .go_i(go), .len_i(plen),
    .oe_n_i(oe_n), .pin_o(pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (pready_o !== 1'b1) n_mismatch++;
    rd = prdata_o;
    err = pslverr_o;
    apb_i <= '0;
  endtask
  // Count cycles the device holds the pin low
  task automatic drive_len();
    n = 0;
    repeat (30) if (oe_n !== 1'b0) @(posedge ref_clk_i);
    while (oe_n === 1'b0 && n < 9000) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask
  task automatic wait_run();
    repeat (9000) if (core_reset_o !== 1'b0) @(posedge ref_clk_i);
    chk(core_reset_o, 1'b0);
    chk(fetch_addr_o, 16'hffff);
    chk(vector_fetch_o, 1'b0);
  endtask
  task automatic t_power_on();
    for (int i = 0; i < 8; i++) begin
      option_i <= '{i[1:0], i[2:0]};
      tick(4);
      chk(clk_sel_o, (i == 6) ? 3'h7 : i[2:0]);
      chk(lvd_level_o, (i[1:0] == 2'h3) ? 2'h2 : i[1:0]);
      chk(osc_run_o, i < 4);
    end
    chk(clk_sel_o, 3'h7);
    below_falling_i <= 1'b0;
    tick(20);
    chk(oe_n, 1'b0);
    above_rising_i <= 1'b1;
    wait_run();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h10);
    above_rising_i <= 1'b0;
    tick(20);
    chk(core_reset_o, 1'b0);
    above_rising_i <= 1'b1;
    apb(1'b1, 8'h04, 32'hf);
  endtask
  task automatic wdg_pulse();
    wdg_underflow_i <= 1'b1;
    @(posedge ref_clk_i);
    wdg_underflow_i <= 1'b0;
    drive_len();
    chk(n >= 200 && n < 9000, 1'b1);
    wait_run();
  endtask
  task automatic t_wdg();
    wdg_pulse();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h11);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h09);
    apb(1'b1, 8'h08, 32'h8);
    tick(2);
    chk(irq_o, 1'b1);
    apb(1'b1, 8'h04, 32'h8);
    tick(2);
    chk(irq_o, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00);
    apb(1'b1, 8'h04, 32'hf);
  endtask
  task automatic t_ext(input logic [7:0] len, input logic hit);
    go <= 1'b1;
    plen <= len;
    @(posedge ref_clk_i);
    go <= 1'b0;
    drive_len();
    chk(n >= 200 && n < 9000, hit);
    if (hit) wait_run();
  endtask
  task automatic t_uv();
    wdg_pulse();
    below_falling_i <= 1'b1;
    above_rising_i <= 1'b0;
    tick(300);
    chk(oe_n, 1'b0);
    below_falling_i <= 1'b0;
    above_rising_i <= 1'b1;
    wait_run();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0f);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask
  // Main sequence
  initial begin
    tick(4);
    rst_n_i <= 1'b1;
    t_power_on();
    t_wdg();
    t_ext(8'h05, 1'b0);
    t_ext(8'h14, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h05);
    t_uv();
    end_of_test();
  end
  // Watchdog
  initial begin
    tick(60000);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
